// >>> pkg/qrw_regs.vh
/*
 * Opcodes, field positions, reset values and dummy counts of the
 * quad read-configuration block.
 * Assumes it is included once by bare name by the design files.
 */
`ifndef QRW_REGS_VH
`define QRW_REGS_VH

// opcodes
`define QRW_OP_WRITE_ENABLE_COMMAND        8'h06
`define QRW_OP_SET_WRAP    8'h77
`define QRW_OP_QCM_ON      8'h38
`define QRW_OP_QCM_OFF     8'hFF
`define QRW_OP_RD_PARAM    8'hC0
`define QRW_OP_PAGE_ERASE  8'h81
`define QRW_OP_WORD_RD     8'hE7
`define QRW_OP_QIO_RD      8'hEB
`define QRW_OP_FAST_RD     8'h0B
`define QRW_OP_WRAP_RD     8'h0C
`define QRW_OP_DTR_WRAP_RD 8'h0E

// bits collected per phase
`define QRW_CMD_BITS       6'h08
`define QRW_ADDR_BITS      6'h18
`define QRW_SET_WRAP_BITS  6'h20
`define QRW_PARAM_BITS     6'h08

// field positions
`define QRW_WRAP_HI        6
`define QRW_WRAP_LO        4
`define QRW_DSEL_HI        5
`define QRW_DSEL_LO        4
`define QRW_WLEN_HI        1
`define QRW_WLEN_LO        0
`define QRW_PAGE_HI        23
`define QRW_PAGE_LO        8

// reset values: wrap disabled, 8-byte length, 10 dummy clocks
`define QRW_WRAP_BITS_RST  3'h1
`define QRW_DSEL_RST       2'h0

// dummy clocks (mode byte included)
`define QRW_DUMMY_SEL0     5'h0A
`define QRW_DUMMY_SEL1     5'h04
`define QRW_DUMMY_SEL2     5'h06
`define QRW_DUMMY_SEL3     5'h08
`define QRW_DUMMY_DC0      5'h06
`define QRW_DUMMY_DC1      5'h08
`define QRW_DUMMY_WORD     5'h04
`define QRW_MODE_CLKS      6'h02
`define QRW_CRM_KEEP       2'h2

// learning pattern
`define QRW_DLP_PATTERN    8'h34
`define QRW_DLP_BITS       6'h08

`endif

// >>> verilog/qrw_sync.v
/*
 * Two flip-flop synchroniser, W bits wide, with a reset value.
 * Assumes each bit is an independent level from another domain.
 */
`timescale 1ns/1ps
module qrw_sync #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= INIT;
			q_o  <= INIT;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule // qrw_sync

// >>> verilog/qrw_fifo2.v
/*
 * Two-entry buffer with valid/ready on both sides and a flush.
 * Assumes flush and traffic share one clock.
 */
`timescale 1ns/1ps
module qrw_fifo2 #(
	parameter W = 8
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire         flush_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:1];
	reg         wp;
	reg         rp;
	reg  [1:0]  cnt;
	wire        push = in_valid_i & in_ready_o;
	wire        pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o  = mem[rp];

	always @(posedge clk_i) begin
		if (push)
			mem[wp] <= in_data_i;
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else if (flush_i) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push)
				wp <= ~wp;
			if (pop)
				rp <= ~rp;
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // qrw_fifo2

// >>> verilog/qrw_top.v
/*
 * Command decoder for wrap reads, read parameters, learning pattern,
 * quad command mode and page erase of a serial multi-line flash.
 * Assumes the host drives chip select, serial clock and I/O lines
 * slowly against CLK_I; array data and erase completion share CLK_I.
 */
`timescale 1ns/1ps
`include "qrw_regs.vh"

module qrw_top (
	input  wire        CLK_I,
	input  wire        RST_N_I,
	input  wire        CS_N_I,
	input  wire        SCLK_I,
	input  wire [3:0]  IO_I,
	output reg  [3:0]  IO_O,
	output reg  [3:0]  IO_OE_N_O,
	input  wire        QUAD_ENABLE_BIT_I,
	input  wire        LEARNING_PATTERN_ENABLE_I,
	input  wire        DUMMY_COUNT_BIT_I,
	input  wire        SOFT_RESET_I,
	output reg         QUAD_COMMAND_MODE_O,
	output reg         WRITE_ENABLE_LATCH_O,
	output reg         WRITE_IN_PROGRESS_FLAG_O,
	output reg  [2:0]  WRAP_BITS_O,
	output reg  [1:0]  DUMMY_SELECT_FIELD_O,
	output reg         RD_REQ_O,
	output reg  [23:0] RD_ADDR_O,
	input  wire [7:0]  RD_DATA_I,
	input  wire        RD_VALID_I,
	output wire        RD_READY_O,
	output reg         ERASE_START_O,
	output reg  [15:0] ERASE_PAGE_O,
	input  wire        ERASE_DONE_I
);
	localparam S_CMD  = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_DUM  = 3'h2;
	localparam S_DATA = 3'h3;
	localparam S_ARG  = 3'h4;
	localparam S_SKIP = 3'h5;

	localparam P_NONE  = 3'h0;
	localparam P_WRITE_ENABLE_COMMAND  = 3'h1;
	localparam P_WRAP  = 3'h2;
	localparam P_PARM  = 3'h3;
	localparam P_ERASE = 3'h4;
	localparam P_QON   = 3'h5;
	localparam P_QOFF  = 3'h6;

	wire        rst_n;
	wire [5:0]  pins;
	reg         csn_d;
	reg         sck_d;
	reg  [2:0]  st;
	reg  [7:0]  opc;
	reg  [31:0] sh;
	reg  [5:0]  nbits;
	reg  [5:0]  need;
	reg  [2:0]  lw;
	reg         dtr;
	reg  [4:0]  dtot;
	reg  [5:0]  mclk;
	reg  [5:0]  dcnt;
	reg         rd_wrap;
	reg  [2:0]  pend;
	reg         done;
	reg         cont;
	reg  [7:0]  cont_opc;
	reg         nib;
	reg  [7:0]  obyte;

	qrw_sync #(.W(1), .INIT(1'b0)) u_rst (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     (1'b1),
		.q_o     (rst_n)
	);

	qrw_sync #(.W(6), .INIT(6'h20)) u_pins (
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.d_i     ({CS_N_I, SCLK_I, IO_I}),
		.q_o     (pins)
	);

	wire       csn   = pins[5];
	wire       sck   = pins[4];
	wire [3:0] io    = pins[3:0];
	wire       start = ~csn & csn_d;
	wire       stop  = csn & ~csn_d;
	wire       rise  = ~csn & sck & ~sck_d;
	wire       fall  = ~csn & ~sck & sck_d;
	wire       quad_command_mode   = QUAD_COMMAND_MODE_O;
	wire       ddr   = dtr & ((st == S_ADDR) | (st == S_DUM));
	// the first double-rate address edge is a rise, not the command's fall
	wire       take  = ddr ? (rise | (fall & ((st != S_ADDR)
		| (nbits != 6'h00)))) : rise;
	wire       drv   = dtr ? (rise | fall) : fall;

	wire [31:0] sh_n = (lw == 3'h4) ? {sh[27:0], io} : {sh[30:0], io[0]};
	wire [5:0]  nb_n = nbits + {3'h0, lw};
	wire        full = (nb_n == need);
	wire [5:0]  dlim = dtr ? {dtot, 1'b0} : {1'b0, dtot};
	wire [5:0]  dc_n = dcnt + 6'h01;

	// dummy count from the read-parameter select field
	reg [4:0] pdum;
	always @* begin
		case (DUMMY_SELECT_FIELD_O)
		2'h0:    pdum = `QRW_DUMMY_SEL0;
		2'h1:    pdum = `QRW_DUMMY_SEL1;
		2'h2:    pdum = `QRW_DUMMY_SEL2;
		default: pdum = `QRW_DUMMY_SEL3;
		endcase
	end

	// opcode decode; a held mode byte replays the last read opcode
	wire [7:0] dop = start ? cont_opc : sh_n[7:0];
	reg  [2:0] d_st;
	reg  [5:0] d_need;
	reg  [2:0] d_lw;
	reg        d_dtr;
	reg  [4:0] d_dtot;
	reg  [5:0] d_mclk;
	reg        d_wrap;
	reg  [2:0] d_pend;
	always @* begin
		d_st   = S_SKIP;
		d_need = `QRW_ADDR_BITS;
		d_lw   = 3'h4;
		d_dtr  = 1'b0;
		d_dtot = pdum;
		d_mclk = 6'h00;
		d_wrap = 1'b0;
		d_pend = P_NONE;
		if (!WRITE_IN_PROGRESS_FLAG_O) begin
			case (dop)
			`QRW_OP_WRITE_ENABLE_COMMAND:
				d_pend = P_WRITE_ENABLE_COMMAND;
			`QRW_OP_SET_WRAP:
				if (!quad_command_mode) begin
					d_st   = S_ARG;
					d_need = `QRW_SET_WRAP_BITS;
					d_lw   = 3'h1;
					d_pend = P_WRAP;
				end
			`QRW_OP_QCM_ON:
				if (!quad_command_mode)
					d_pend = P_QON;
			`QRW_OP_QCM_OFF:
				if (quad_command_mode)
					d_pend = P_QOFF;
			`QRW_OP_RD_PARAM:
				if (quad_command_mode) begin
					d_st   = S_ARG;
					d_need = `QRW_PARAM_BITS;
					d_pend = P_PARM;
				end
			`QRW_OP_PAGE_ERASE: begin
				d_st   = S_ARG;
				d_lw   = quad_command_mode ? 3'h4 : 3'h1;
				d_pend = P_ERASE;
			end
			`QRW_OP_WORD_RD:
				if (!quad_command_mode) begin
					d_st   = S_ADDR;
					d_dtot = `QRW_DUMMY_WORD;
					d_mclk = `QRW_MODE_CLKS;
					d_wrap = ~WRAP_BITS_O[0];
				end
			`QRW_OP_QIO_RD: begin
				d_st   = S_ADDR;
				d_mclk = `QRW_MODE_CLKS;
				if (!quad_command_mode) begin
					d_dtot = DUMMY_COUNT_BIT_I ? `QRW_DUMMY_DC1
						: `QRW_DUMMY_DC0;
					d_wrap = ~WRAP_BITS_O[0];
				end
			end
			`QRW_OP_FAST_RD:
				if (quad_command_mode)
					d_st = S_ADDR;
			`QRW_OP_WRAP_RD:
				if (quad_command_mode) begin
					d_st   = S_ADDR;
					d_wrap = 1'b1;
				end
			`QRW_OP_DTR_WRAP_RD:
				if (quad_command_mode) begin
					d_st   = S_ADDR;
					d_wrap = 1'b1;
					d_dtr  = 1'b1;
				end
			default: ;
			endcase
		end
	end

	// read data path: fetch address walks, wrapping inside its section when rd_wrap is set
	wire [7:0]  wmask = (8'h08 << WRAP_BITS_O[2:1]) - 8'h01;
	wire [23:0] inc   = RD_ADDR_O + 24'h000001;
	wire [23:0] nxt   = rd_wrap ? ((RD_ADDR_O & ~{16'h0000, wmask})
		| (inc & {16'h0000, wmask})) : inc;
	wire        f_ready;
	wire        f_valid;
	wire [7:0]  f_data;
	wire        pop = drv & (st == S_DATA) & ~nib & ~start & ~stop;
	wire [7:0]  byte_out = f_valid ? f_data : 8'hFF;

	assign RD_READY_O = f_ready & RD_REQ_O;

	qrw_fifo2 #(.W(8)) u_buf (
		.clk_i       (CLK_I),
		.rst_n_i     (rst_n),
		.flush_i     (start | stop),
		.in_valid_i  (RD_VALID_I & RD_REQ_O),
		.in_ready_o  (f_ready),
		.in_data_i   (RD_DATA_I),
		.out_valid_o (f_valid),
		.out_ready_i (pop),
		.out_data_o  (f_data)
	);

	// frame sequencing and configuration state
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			csn_d <= 1'b1;
			sck_d <= 1'b0;
			st <= S_CMD;
			opc <= 8'h00;
			sh <= 32'h00000000;
			nbits <= 6'h00;
			need <= `QRW_CMD_BITS;
			lw <= 3'h1;
			dtr <= 1'b0;
			dtot <= `QRW_DUMMY_SEL0;
			mclk <= 6'h00;
			dcnt <= 6'h00;
			rd_wrap <= 1'b0;
			pend <= P_NONE;
			done <= 1'b0;
			cont <= 1'b0;
			cont_opc <= 8'h00;
			QUAD_COMMAND_MODE_O <= 1'b0;
			WRITE_ENABLE_LATCH_O <= 1'b0;
			WRITE_IN_PROGRESS_FLAG_O <= 1'b0;
			WRAP_BITS_O <= `QRW_WRAP_BITS_RST;
			DUMMY_SELECT_FIELD_O <= `QRW_DSEL_RST;
			RD_REQ_O <= 1'b0;
			RD_ADDR_O <= 24'h000000;
			ERASE_START_O <= 1'b0;
			ERASE_PAGE_O <= 16'h0000;
		end else begin
			csn_d <= csn;
			sck_d <= sck;
			ERASE_START_O <= 1'b0;
			if (ERASE_DONE_I & WRITE_IN_PROGRESS_FLAG_O) begin
				WRITE_IN_PROGRESS_FLAG_O <= 1'b0;
				WRITE_ENABLE_LATCH_O <= 1'b0;
			end
			if (SOFT_RESET_I) begin
				WRAP_BITS_O <= `QRW_WRAP_BITS_RST;
				DUMMY_SELECT_FIELD_O <= `QRW_DSEL_RST;
				cont <= 1'b0;
			end
			if (RD_REQ_O & RD_VALID_I & RD_READY_O)
				RD_ADDR_O <= nxt;
			if (start) begin
				sh <= 32'h00000000;
				nbits <= 6'h00;
				dcnt <= 6'h00;
				done <= 1'b0;
				pend <= P_NONE;
				RD_REQ_O <= 1'b0;
				if (cont & ~WRITE_IN_PROGRESS_FLAG_O) begin
					st <= S_ADDR;
					opc <= cont_opc;
					need <= d_need;
					lw <= d_lw;
					dtr <= d_dtr;
					dtot <= d_dtot;
					mclk <= d_mclk;
					rd_wrap <= d_wrap;
				end else begin
					st <= S_CMD;
					need <= `QRW_CMD_BITS;
					lw <= quad_command_mode ? 3'h4 : 3'h1;
					dtr <= 1'b0;
				end
			end else if (stop) begin
				st <= S_CMD;
				RD_REQ_O <= 1'b0;
				if (done) begin
					case (pend)
					P_WRITE_ENABLE_COMMAND:
						WRITE_ENABLE_LATCH_O <= 1'b1;
					P_WRAP:
						WRAP_BITS_O <= sh[`QRW_WRAP_HI:`QRW_WRAP_LO];
					P_PARM: begin
						DUMMY_SELECT_FIELD_O <= sh[`QRW_DSEL_HI:`QRW_DSEL_LO];
						WRAP_BITS_O[2:1] <= sh[`QRW_WLEN_HI:`QRW_WLEN_LO];
					end
					P_ERASE:
						if (WRITE_ENABLE_LATCH_O) begin
							ERASE_START_O <= 1'b1;
							ERASE_PAGE_O <= sh[`QRW_PAGE_HI:`QRW_PAGE_LO];
							WRITE_IN_PROGRESS_FLAG_O <= 1'b1;
						end
					P_QON:
						if (QUAD_ENABLE_BIT_I)
							QUAD_COMMAND_MODE_O <= 1'b1;
					P_QOFF:
						QUAD_COMMAND_MODE_O <= 1'b0;
					default: ;
					endcase
				end
			end else if (take) begin
				sh <= sh_n;
				nbits <= nb_n;
				case (st)
				S_CMD:
					if (full) begin
						opc <= sh_n[7:0];
						st <= d_st;
						nbits <= 6'h00;
						need <= d_need;
						lw <= d_lw;
						dtr <= d_dtr;
						dtot <= d_dtot;
						mclk <= d_mclk;
						rd_wrap <= d_wrap;
						pend <= d_pend;
						done <= (d_st == S_SKIP);
					end
				S_ADDR:
					if (full) begin
						st <= S_DUM;
						RD_ADDR_O <= sh_n[23:0];
						RD_REQ_O <= 1'b1;
					end
				S_DUM: begin
					dcnt <= dc_n;
					if ((mclk != 6'h00) && (dc_n == mclk)) begin
						cont <= (sh_n[5:4] == `QRW_CRM_KEEP);
						cont_opc <= opc;
					end
					if (dc_n == dlim)
						st <= S_DATA;
				end
				S_ARG:
					if (full) begin
						st <= S_SKIP;
						done <= 1'b1;
					end
				S_SKIP:
					done <= 1'b0;
				default: ;
				endcase
			end
		end
	end

	// learning pattern position inside the dummy period
	wire [5:0] dlp_base = dtr ? (dlim - `QRW_DLP_BITS) : mclk;
	wire [5:0] dlp_k    = dcnt - dlp_base;
	wire       dlp_on   = LEARNING_PATTERN_ENABLE_I & (dcnt >= dlp_base)
		& (dlp_k < `QRW_DLP_BITS);
	wire [7:0] dlp_pat  = `QRW_DLP_PATTERN;
	wire       dlp_bit  = dlp_pat[3'h7 - dlp_k[2:0]];

	// output lanes
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			IO_O <= 4'h0;
			IO_OE_N_O <= 4'hF;
			nib <= 1'b0;
			obyte <= 8'h00;
		end else if (start | stop) begin
			IO_OE_N_O <= 4'hF;
			nib <= 1'b0;
		end else if (drv) begin
			if (st == S_DATA) begin
				nib <= ~nib;
				IO_OE_N_O <= 4'h0;
				if (!nib) begin
					IO_O <= byte_out[7:4];
					obyte <= byte_out;
				end else begin
					IO_O <= obyte[3:0];
				end
			end else if ((st == S_DUM) && dlp_on) begin
				IO_OE_N_O <= 4'h0;
				IO_O <= {4{dlp_bit}};
			end else begin
				IO_OE_N_O <= 4'hF;
			end
		end
	end
endmodule // qrw_top

// >>> tb/qrw_asserts.sv
/* Pin-level checker for the quad read-configuration decoder.
 * Assumes it is bound into qrw_top and sees only its ports. */
`timescale 1ns/1ps
module qrw_asserts (
	input wire        CLK_I,
	input wire        RST_N_I,
	input wire        CS_N_I,
	input wire [3:0]  IO_OE_N_O,
	input wire        QUAD_ENABLE_BIT_I,
	input wire        SOFT_RESET_I,
	input wire        QUAD_COMMAND_MODE_O,
	input wire        WRITE_ENABLE_LATCH_O,
	input wire        WRITE_IN_PROGRESS_FLAG_O,
	input wire [2:0]  WRAP_BITS_O,
	input wire [1:0]  DUMMY_SELECT_FIELD_O,
	input wire        RD_REQ_O,
	input wire [23:0] RD_ADDR_O,
	input wire        RD_VALID_I,
	input wire        RD_READY_O,
	input wire        ERASE_START_O,
	input wire        ERASE_DONE_I
);
	wire acc = RD_REQ_O & RD_VALID_I & RD_READY_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_oe_idle: assert property (CS_N_I [*8] |-> IO_OE_N_O == 4'hF)
		else $error("lines driven while idle");
	a_addr_step: assert property (acc ##1 RD_REQ_O |->
		RD_ADDR_O[2:0] == $past(RD_ADDR_O[2:0]) + 3'h1)
		else $error("fetch address did not step");
	a_ready_gate: assert property (!RD_REQ_O |-> !RD_READY_O)
		else $error("ready without fetch");
	a_addr_hold: assert property (RD_REQ_O && !acc ##1 RD_REQ_O |->
		$stable(RD_ADDR_O)) else $error("fetch address moved early");
	a_erase_pulse: assert property (ERASE_START_O |=> !ERASE_START_O)
		else $error("erase start too long");
	a_erase_busy: assert property (ERASE_START_O |-> ##[0:1]
		WRITE_IN_PROGRESS_FLAG_O) else $error("busy flag not set");
	a_erase_latch: assert property (ERASE_START_O |->
		$past(WRITE_ENABLE_LATCH_O)) else $error("erase without latch");
	a_erase_cs: assert property (ERASE_START_O |-> CS_N_I)
		else $error("erase before deselect");
	a_done_clears: assert property (ERASE_DONE_I &&
		WRITE_IN_PROGRESS_FLAG_O |=> !WRITE_IN_PROGRESS_FLAG_O &&
		!WRITE_ENABLE_LATCH_O) else $error("done did not clear");
	a_mode_qe: assert property ($rose(QUAD_COMMAND_MODE_O) |->
		QUAD_ENABLE_BIT_I && CS_N_I) else $error("mode entered wrongly");
	a_mode_keep: assert property ($rose(QUAD_COMMAND_MODE_O) |->
		$stable(WRITE_ENABLE_LATCH_O) && $stable(WRAP_BITS_O))
		else $error("mode change altered state");
	a_dsel_cs: assert property ($changed(DUMMY_SELECT_FIELD_O) |->
		CS_N_I || $past(SOFT_RESET_I)) else $error("select moved in frame");
	a_wrap_cs: assert property ($changed(WRAP_BITS_O) |->
		CS_N_I || $past(SOFT_RESET_I)) else $error("wrap moved in frame");
endmodule // qrw_asserts
bind qrw_top qrw_asserts u_chk (.CLK_I, .RST_N_I, .CS_N_I, .IO_OE_N_O,
	.QUAD_ENABLE_BIT_I, .SOFT_RESET_I, .QUAD_COMMAND_MODE_O,
	.WRITE_ENABLE_LATCH_O, .WRITE_IN_PROGRESS_FLAG_O, .WRAP_BITS_O,
	.DUMMY_SELECT_FIELD_O, .RD_REQ_O, .RD_ADDR_O, .RD_VALID_I,
	.RD_READY_O, .ERASE_START_O, .ERASE_DONE_I);

// >>> tb/qrw_host_model.sv
/* Host controller model: chip select, serial clock, shared lines.
 * Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module qrw_host_model (
	output reg        cs_n,
	output reg        sclk,
	output wire [3:0] io_pin,
	input  wire [3:0] io_o,
	input  wire [3:0] io_oe_n
);
	reg     [3:0] drv;
	integer       i;
	assign io_pin = (io_o & ~io_oe_n) | (drv & io_oe_n);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
	end
	// lines change while the clock is low, sampled just before the rise
	task clk1(input [3:0] d, output [3:0] q);
		begin
			sclk = 1'b0;
			drv = d;
			#62.5;
			q = io_pin;
			sclk = 1'b1;
			#62.5;
		end
	endtask
	// double-rate clock: lines change mid-phase, sampled before each edge
	task dclk(input [3:0] d0, input [3:0] d1, output [3:0] qa,
		output [3:0] qb);
		begin
			qa = io_pin;
			sclk = 1'b0;
			#31.25;
			drv = d0;
			#31.25;
			qb = io_pin;
			sclk = 1'b1;
			#31.25;
			drv = d1;
			#31.25;
		end
	endtask
	task sel;
		begin
			cs_n = 1'b0;
			#62.5;
		end
	endtask
	task send(input [39:0] v, input integer n, input integer w);
		reg [3:0] q;
		begin
			for (i = n - w; i >= 0; i = i - w)
				clk1(w == 4 ? v[i+:4] : {3'h0, v[i]}, q);
		end
	endtask
	// released lines show a changing pattern, not the last value
	task rd(output [3:0] q);
		clk1(~drv, q);
	endtask
	task desel;
		begin
			sclk = 1'b0;
			#62.5;
			cs_n = 1'b1;
			drv = ~drv;
			#250;
		end
	endtask
endmodule // qrw_host_model

// >>> tb/testbench.sv
/* Random and corner-case bench for the quad read-configuration decoder.
 * Assumes the host model on the link and an array stub in here. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	total_checks = total_checks + 1; \
	if ((g) !== (e)) begin \
		failures = failures + 1; \
		$display("[ERR] %s exp %0h got %0h", n, e, g); \
	end \
end
module testbench;
	localparam [7:0] PAT = 8'h34;
	reg         CLK_I = 1'b0;
	reg         RST_N_I = 1'b0;
	reg         QUAD_ENABLE_BIT_I = 1'b0;
	reg         LEARNING_PATTERN_ENABLE_I = 1'b0;
	reg         DUMMY_COUNT_BIT_I = 1'b0;
	reg         SOFT_RESET_I = 1'b0;
	reg  [7:0]  RD_DATA_I = 8'h00;
	reg         RD_VALID_I = 1'b0;
	reg         ERASE_DONE_I = 1'b0;
	wire        CS_N_I, SCLK_I, QUAD_COMMAND_MODE_O, WRITE_ENABLE_LATCH_O;
	wire        WRITE_IN_PROGRESS_FLAG_O, RD_REQ_O, RD_READY_O, ERASE_START_O;
	wire [3:0]  IO_I, IO_O, IO_OE_N_O;
	wire [2:0]  WRAP_BITS_O;
	wire [1:0]  DUMMY_SELECT_FIELD_O;
	wire [23:0] RD_ADDR_O;
	wire [15:0] ERASE_PAGE_O;
	reg  [31:0] seed = 32'hCC8D;
	reg  [31:0] sseed = 32'hCC8D;
	integer     failures = 0, total_checks = 0, cycles = 0, starts = 0, i;
	reg  [23:0] a, j, len;
	reg  [7:0]  w, p;
	reg  [15:0] pg;
	reg  [3:0]  q, q2;
	always #2 CLK_I = ~CLK_I;
	qrw_top uut (.CLK_I, .RST_N_I, .CS_N_I, .SCLK_I, .IO_I, .IO_O,
		.IO_OE_N_O, .QUAD_ENABLE_BIT_I, .LEARNING_PATTERN_ENABLE_I,
		.DUMMY_COUNT_BIT_I, .SOFT_RESET_I, .QUAD_COMMAND_MODE_O,
		.WRITE_ENABLE_LATCH_O, .WRITE_IN_PROGRESS_FLAG_O, .WRAP_BITS_O,
		.DUMMY_SELECT_FIELD_O, .RD_REQ_O, .RD_ADDR_O, .RD_DATA_I,
		.RD_VALID_I, .RD_READY_O, .ERASE_START_O, .ERASE_PAGE_O,
		.ERASE_DONE_I);
	qrw_host_model h (.cs_n(CS_N_I), .sclk(SCLK_I), .io_pin(IO_I),
		.io_o(IO_O), .io_oe_n(IO_OE_N_O));
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function [7:0] exp_byte(input [23:0] s, input [23:0] n, input [23:0] k);
		reg [23:0] ad;
		begin
			ad = (s & ~(n - 24'h1)) | ((s + k) & (n - 24'h1));
			exp_byte = ad[7:0] ^ 8'h5A;
		end
	endfunction
	// array stub stalls at random
	always @(negedge CLK_I) begin
		sseed <= xs(sseed);
		RD_VALID_I <= RD_REQ_O & sseed[1];
		RD_DATA_I <= RD_ADDR_O[7:0] ^ 8'h5A;
	end
	task summarize;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	always @(posedge CLK_I) begin
		cycles <= cycles + 1;
		if (ERASE_START_O)
			starts <= starts + 1;
		if (cycles == 60000) begin
			failures = failures + 1;
			summarize();
		end
	end
	task frame(input [39:0] v, input integer n, input integer wd);
		begin
			h.sel();
			h.send(v, n, wd);
			h.desel();
			repeat (8) @(negedge CLK_I);
		end
	endtask
	// pattern bits then data bytes of a single-rate read, then deselect
	task burst(input [23:0] s, input [23:0] n, input integer np,
		input [23:0] nd);
		begin
			for (i = 0; i < np; i = i + 1) begin
				h.rd(q);
				`CHK("pattern", {4{PAT[7 - i]}}, q)
			end
			for (j = 0; j < nd; j = j + 24'h1) begin
				h.rd(q);
				h.rd(q2);
				`CHK("data", exp_byte(s, n, j), {q, q2})
			end
			h.desel();
		end
	endtask
	initial begin
		repeat (8) @(negedge CLK_I);
		RST_N_I = 1'b1;
		seed = xs(seed);
		DUMMY_COUNT_BIT_I = seed[0];
		repeat (6) @(negedge CLK_I);
		`CHK("wrap", 3'h1, WRAP_BITS_O)
		`CHK("dsel", 2'h0, DUMMY_SELECT_FIELD_O)
		frame({8'hC0, 8'h30}, 16, 1);
		`CHK("dsel", 2'h0, DUMMY_SELECT_FIELD_O)
		frame(8'h38, 8, 1);
		`CHK("qcm", 1'b0, QUAD_COMMAND_MODE_O)
		seed = xs(seed);
		w = seed[7:0] & 8'hEF;
		frame({8'h77, 24'h0, w}, 40, 1);
		`CHK("wrap", w[6:4], WRAP_BITS_O)
		QUAD_ENABLE_BIT_I = 1'b1;
		frame(8'h06, 8, 1);
		frame(8'h38, 8, 1);
		`CHK("qcm", 1'b1, QUAD_COMMAND_MODE_O)
		`CHK("wel", 1'b1, WRITE_ENABLE_LATCH_O)
		`CHK("wrap", w[6:4], WRAP_BITS_O)
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			p = seed[7:0];
			p[5:4] = i[1:0] + 2'h2;
			frame({8'hC0, p}, 16, 4);
			`CHK("dsel", p[5:4], DUMMY_SELECT_FIELD_O)
			`CHK("wlen", p[1:0], WRAP_BITS_O[2:1])
		end
		LEARNING_PATTERN_ENABLE_I = 1'b1;
		seed = xs(seed);
		a = seed[23:0];
		len = 24'h8 << p[1:0];
		h.sel();
		h.send({8'h0C, a}, 32, 4);
		burst(a, len, 4, len + 24'h3);
		seed = xs(seed);
		a = seed[23:0];
		h.sel();
		h.send(8'h0E, 8, 4);
		h.dclk(a[23:20], a[19:16], q, q2);
		h.dclk(a[15:12], a[11:8], q, q2);
		h.dclk(a[7:4], a[3:0], q, q2);
		h.dclk(4'h0, 4'h0, q, q2);
		for (i = 0; i < 8; i = i + 2) begin
			h.dclk(4'h0, 4'h0, q, q2);
			`CHK("ddr pat", {{4{PAT[7-i]}}, {4{PAT[6-i]}}}, {q, q2})
		end
		for (j = 0; j < len + 24'h3; j = j + 24'h1) begin
			h.dclk(4'h0, 4'h0, q, q2);
			`CHK("ddr data", exp_byte(a, len, j), {q, q2})
		end
		h.desel();
		seed = xs(seed);
		pg = seed[15:0];
		frame({8'h81, pg, 8'h00}, 32, 4);
		`CHK("page", pg, ERASE_PAGE_O)
		`CHK("starts", 1, starts)
		`CHK("wip", 1'b1, WRITE_IN_PROGRESS_FLAG_O)
		@(negedge CLK_I);
		ERASE_DONE_I = 1'b1;
		@(negedge CLK_I);
		ERASE_DONE_I = 1'b0;
		repeat (2) @(negedge CLK_I);
		`CHK("wip", 1'b0, WRITE_IN_PROGRESS_FLAG_O)
		`CHK("wel", 1'b0, WRITE_ENABLE_LATCH_O)
		frame(8'hFF, 8, 4);
		`CHK("qcm", 1'b0, QUAD_COMMAND_MODE_O)
		`CHK("wlen", p[1:0], WRAP_BITS_O[2:1])
		seed = xs(seed);
		a = seed[23:0] & 24'hFFFFFE;
		h.sel();
		h.send(8'hE7, 8, 1);
		h.send({a, 8'h00}, 32, 4);
		burst(a, len, 2, len + 24'h3);
		frame({8'h81, pg, 8'h00}, 32, 1);
		`CHK("starts", 1, starts)
		frame({8'h77, 24'h0, 8'h70}, 40, 1);
		`CHK("wrap", 3'h7, WRAP_BITS_O)
		h.sel();
		h.send(8'hEB, 8, 1);
		h.send({a, 8'h00}, 32, 4);
		burst(a, 24'h0, DUMMY_COUNT_BIT_I ? 6 : 4, 24'h9);
		@(negedge CLK_I);
		SOFT_RESET_I = 1'b1;
		@(negedge CLK_I);
		SOFT_RESET_I = 1'b0;
		repeat (2) @(negedge CLK_I);
		`CHK("wrap", 3'h1, WRAP_BITS_O)
		`CHK("dsel", 2'h0, DUMMY_SELECT_FIELD_O)
		summarize();
	end
endmodule // testbench
